//--- hdl/tss_pkg.sv
package tss_pkg;

    localparam int WORD_BITS  = 16;
    localparam int MASK_BITS  = 32;
    localparam int ADDR_BITS  = 4;
    localparam int DIV_BITS   = 5;
    localparam int SLOT_BITS  = 5;
    localparam int BIT_BITS   = 4;
    localparam int CTRL_WIDTH = 11;
    localparam int SYNC_WIDTH = 3;

    localparam int REF_CLK_PERIOD_NS = 10;

    localparam logic [ADDR_BITS-1:0] OFS_CTRL        = 4'h0;
    localparam logic [ADDR_BITS-1:0] OFS_STATUS      = 4'h1;
    localparam logic [ADDR_BITS-1:0] OFS_XMIT_DATA   = 4'h2;
    localparam logic [ADDR_BITS-1:0] OFS_RCV_DATA    = 4'h3;
    localparam logic [ADDR_BITS-1:0] OFS_SKIP_SLOT   = 4'h4;
    localparam logic [ADDR_BITS-1:0] OFS_XMASK_A     = 4'h5;
    localparam logic [ADDR_BITS-1:0] OFS_XMASK_B     = 4'h6;
    localparam logic [ADDR_BITS-1:0] OFS_RMASK_A     = 4'h7;
    localparam logic [ADDR_BITS-1:0] OFS_RMASK_B     = 4'h8;

    localparam logic [BIT_BITS-1:0]  LAST_BIT        = 4'hF;
    localparam logic [WORD_BITS-1:0] RESET_MASK_HALF = 16'hFFFF;
    localparam logic [MASK_BITS-1:0] RESET_MASK_FULL = 32'hFFFFFFFF;
    localparam logic [WORD_BITS-1:0] RESET_WORD      = 16'h0000;

    // control word, bit 0 is xmit_enable, frame divider in bits 10..6
    typedef struct packed {
        logic [DIV_BITS-1:0] frame_divider_field;
        logic                fs_internal;
        logic                network;
        logic                rcv_irq_enable;
        logic                xmit_irq_enable;
        logic                rcv_enable;
        logic                xmit_enable;
    } tss_ctrl_type;

    // status word, bit 0 is xmit_empty_flag
    typedef struct packed {
        logic rcv_frame_sync;
        logic xmit_frame_sync;
        logic rcv_overrun_flag;
        logic xmit_underrun_flag;
        logic rcv_full_flag;
        logic xmit_empty_flag;
    } tss_flags_type;

    localparam int STATUS_WIDTH = 6;
    localparam tss_flags_type RESET_FLAGS = 6'h01;

    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic [ADDR_BITS-1:0] addr;
        logic [WORD_BITS-1:0] wdata;
    } tss_reg_req_type;

    typedef struct packed {
        logic serial_out_pin;
        logic serial_out_oe;
        logic fs_out;
        logic fs_oe;
    } tss_pin_out_type;

endpackage : tss_pkg

//--- hdl/tss_sync.sv
module tss_sync
#(
    parameter int WIDTH = 3
)
(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } tss_sync_state_type;

    tss_sync_state_type state;
    tss_sync_state_type next_state;

    // stage1 feeds stage2 only, so a metastable sample never reaches logic
    always_comb
    begin
        next_state        = state;
        next_state.stage1 = d;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign q = state.stage2;

endmodule : tss_sync

//--- hdl/tss_sequencer.sv
module tss_sequencer
(
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire tss_pkg::tss_reg_req_type req,
    output logic [tss_pkg::WORD_BITS-1:0] rd_data,
    input  wire logic                     sck_in,
    input  wire logic                     fs_in,
    input  wire logic                     rxd_in,
    output tss_pkg::tss_pin_out_type      pins,
    output logic                          xmit_irq,
    output logic                          rcv_irq
);
    import tss_pkg::*;

    typedef struct packed {
        tss_ctrl_type         ctrl;
        tss_flags_type        flags;
        logic [WORD_BITS-1:0] xmit_slot_mask_half_a;
        logic [WORD_BITS-1:0] xmit_slot_mask_half_b;
        logic [WORD_BITS-1:0] rcv_slot_mask_half_a;
        logic [WORD_BITS-1:0] rcv_slot_mask_half_b;
        logic [MASK_BITS-1:0] xmit_mask_shifter;
        logic [MASK_BITS-1:0] rcv_mask_shifter;
        logic [WORD_BITS-1:0] xmit_hold;
        logic [WORD_BITS-1:0] xmit_last;
        logic [WORD_BITS-1:0] xmit_shift;
        logic [WORD_BITS-1:0] rcv_hold;
        logic [WORD_BITS-1:0] rcv_shift;
        logic [WORD_BITS-1:0] rd_data;
        logic [BIT_BITS-1:0]  bit_pos;
        logic [SLOT_BITS-1:0] slot_pos;
        logic                 in_word;
        logic                 sck_prev;
        logic                 fs_hit;
        logic                 fs_out;
        logic                 xmit_drive;
        logic                 xmit_armed;
        logic                 rcv_armed;
        logic                 xmit_dropped;
        logic                 rcv_dropped;
        logic                 skip_pend;
        logic                 underrun_seen;
        logic                 overrun_seen;
        logic                 xmit_first;
        logic                 rcv_first;
    } tss_state_type;

    tss_state_type        state;
    tss_state_type        next_state;
    logic [SYNC_WIDTH-1:0] link_q;
    logic                 sck_rise;
    logic                 sck_fall;
    logic                 on_demand;
    logic                 start_frame;
    logic                 new_word;
    logic                 xmit_active;
    logic                 rcv_active;
    logic [SLOT_BITS-1:0] last_slot;
    logic [WORD_BITS-1:0] rcv_word;

    // data and frame sync share one synchroniser with the clock to keep alignment
    tss_sync #(
        .WIDTH (SYNC_WIDTH)
    ) u_link_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       ({sck_in, fs_in, rxd_in}),
        .q       (link_q)
    );

    always_comb
    begin
        next_state  = state;
        next_state.rd_data = RESET_WORD;
        sck_rise    = link_q[2] & ~state.sck_prev;
        sck_fall    = ~link_q[2] & state.sck_prev;
        next_state.sck_prev = link_q[2];
        // on-demand needs our own frame sync; an external one keeps a one-slot frame
        on_demand   = state.ctrl.network && state.ctrl.fs_internal &&
                      (state.ctrl.frame_divider_field == '0);
        last_slot   = state.ctrl.frame_divider_field;
        start_frame = 1'b0;
        new_word    = 1'b0;
        xmit_active = 1'b0;
        rcv_active  = 1'b0;
        rcv_word    = {state.rcv_shift[WORD_BITS-2:0], link_q[0]};

        if (req.wr)
        begin
            if (req.addr == OFS_CTRL)
            begin
                next_state.ctrl = tss_ctrl_type'(req.wdata[CTRL_WIDTH-1:0]);
            end
            else if (req.addr == OFS_XMIT_DATA || req.addr == OFS_SKIP_SLOT)
            begin
                if (req.addr == OFS_XMIT_DATA)
                begin
                    next_state.xmit_hold = req.wdata;
                end
                next_state.skip_pend = (req.addr == OFS_SKIP_SLOT);
                next_state.flags.xmit_empty_flag = 1'b0;
                if (state.underrun_seen)
                begin
                    next_state.flags.xmit_underrun_flag = 1'b0;
                    next_state.underrun_seen = 1'b0;
                end
            end
            else if (req.addr == OFS_XMASK_A)
            begin
                next_state.xmit_slot_mask_half_a = req.wdata;
            end
            else if (req.addr == OFS_XMASK_B)
            begin
                next_state.xmit_slot_mask_half_b = req.wdata;
            end
            else if (req.addr == OFS_RMASK_A)
            begin
                next_state.rcv_slot_mask_half_a = req.wdata;
            end
            else if (req.addr == OFS_RMASK_B)
            begin
                next_state.rcv_slot_mask_half_b = req.wdata;
            end
        end

        if (req.rd)
        begin
            if (req.addr == OFS_CTRL)
            begin
                next_state.rd_data = {5'h00, state.ctrl};
            end
            else if (req.addr == OFS_STATUS)
            begin
                next_state.rd_data = {10'h000, state.flags};
                next_state.underrun_seen = state.flags.xmit_underrun_flag;
                next_state.overrun_seen  = state.flags.rcv_overrun_flag;
            end
            else if (req.addr == OFS_RCV_DATA)
            begin
                next_state.rd_data = state.rcv_hold;
                next_state.flags.rcv_full_flag = 1'b0;
                if (state.overrun_seen)
                begin
                    next_state.flags.rcv_overrun_flag = 1'b0;
                    next_state.overrun_seen = 1'b0;
                end
            end
            else if (req.addr == OFS_XMASK_A)
            begin
                next_state.rd_data = state.xmit_slot_mask_half_a;
            end
            else if (req.addr == OFS_XMASK_B)
            begin
                next_state.rd_data = state.xmit_slot_mask_half_b;
            end
            else if (req.addr == OFS_RMASK_A)
            begin
                next_state.rd_data = state.rcv_slot_mask_half_a;
            end
            else if (req.addr == OFS_RMASK_B)
            begin
                next_state.rd_data = state.rcv_slot_mask_half_b;
            end
        end

        // a low enable at any moment is remembered until the next frame sync
        if (!next_state.ctrl.xmit_enable)
        begin
            next_state.xmit_dropped = 1'b1;
        end
        if (!next_state.ctrl.rcv_enable)
        begin
            next_state.rcv_dropped = 1'b1;
        end

        if (sck_rise)
        begin
            next_state.fs_hit = link_q[1];
            if (state.in_word)
            begin
                next_state.rcv_shift = rcv_word;
                if (state.bit_pos == LAST_BIT)
                begin
                    rcv_active = state.ctrl.network ? state.rcv_mask_shifter[0]
                                                    : (state.slot_pos == '0);
                    if (state.rcv_armed && rcv_active)
                    begin
                        if (next_state.flags.rcv_full_flag)
                        begin
                            next_state.flags.rcv_overrun_flag = 1'b1;
                        end
                        else
                        begin
                            next_state.rcv_hold = rcv_word;
                            next_state.flags.rcv_full_flag = 1'b1;
                            next_state.flags.rcv_frame_sync = state.rcv_first;
                        end
                        next_state.rcv_first = 1'b0;
                    end
                    if (state.slot_pos == last_slot)
                    begin
                        next_state.rcv_mask_shifter = {next_state.rcv_slot_mask_half_b,
                                                       next_state.rcv_slot_mask_half_a};
                        next_state.xmit_mask_shifter = {next_state.xmit_slot_mask_half_b,
                                                        next_state.xmit_slot_mask_half_a};
                    end
                    else
                    begin
                        next_state.rcv_mask_shifter  = state.rcv_mask_shifter >> 1;
                        next_state.xmit_mask_shifter = state.xmit_mask_shifter >> 1;
                    end
                end
            end
        end

        if (sck_fall)
        begin
            next_state.fs_out = 1'b0;
            // the frame counter ignores the enables except in on-demand mode, where a frame starts only with xmit_enable set
            if (!state.ctrl.fs_internal)
            begin
                start_frame = state.fs_hit;
            end
            else if (on_demand)
            begin
                start_frame = (!state.in_word || state.bit_pos == LAST_BIT) &&
                              !next_state.flags.xmit_empty_flag &&
                              next_state.ctrl.xmit_enable;
            end
            else
            begin
                start_frame = !state.in_word ||
                              (state.bit_pos == LAST_BIT && state.slot_pos == last_slot);
            end

            if (start_frame)
            begin
                next_state.in_word  = 1'b1;
                next_state.bit_pos  = '0;
                next_state.slot_pos = '0;
                next_state.fs_out   = state.ctrl.fs_internal;
                new_word            = 1'b1;
            end
            else if (state.in_word)
            begin
                if (state.bit_pos == LAST_BIT)
                begin
                    if (state.slot_pos == last_slot)
                    begin
                        next_state.in_word    = 1'b0;
                        next_state.xmit_drive = 1'b0;
                    end
                    else
                    begin
                        next_state.bit_pos  = '0;
                        next_state.slot_pos = state.slot_pos + 5'h01;
                        new_word            = 1'b1;
                    end
                end
                else
                begin
                    next_state.bit_pos    = state.bit_pos + 4'h1;
                    next_state.xmit_shift = {state.xmit_shift[WORD_BITS-2:0], 1'b0};
                end
            end

            if (new_word)
            begin
                if (start_frame)
                begin
                    next_state.xmit_armed   = next_state.ctrl.xmit_enable;
                    next_state.rcv_armed    = next_state.ctrl.rcv_enable;
                    next_state.xmit_dropped = !next_state.ctrl.xmit_enable;
                    next_state.rcv_dropped  = !next_state.ctrl.rcv_enable;
                    next_state.xmit_first   = 1'b1;
                    next_state.rcv_first    = 1'b1;
                end
                else
                begin
                    if (next_state.xmit_dropped)
                    begin
                        next_state.xmit_armed = 1'b0;
                    end
                    if (next_state.rcv_dropped)
                    begin
                        next_state.rcv_armed = 1'b0;
                    end
                end
                xmit_active = state.ctrl.network ? state.xmit_mask_shifter[0]
                                                 : (next_state.slot_pos == '0);
                next_state.xmit_drive = 1'b0;
                if (next_state.xmit_armed && xmit_active)
                begin
                    if (!next_state.flags.xmit_empty_flag)
                    begin
                        next_state.xmit_shift = next_state.xmit_hold;
                        next_state.xmit_last  = next_state.xmit_hold;
                        next_state.flags.xmit_empty_flag = 1'b1;
                        next_state.xmit_drive = !next_state.skip_pend;
                        next_state.skip_pend  = 1'b0;
                    end
                    else
                    begin
                        // on-demand never gets here: it only starts on written data
                        next_state.flags.xmit_underrun_flag = 1'b1;
                        next_state.xmit_shift = state.xmit_last;
                        next_state.xmit_drive = 1'b1;
                    end
                    next_state.flags.xmit_frame_sync = state.xmit_first;
                    next_state.xmit_first = 1'b0;
                end
                else if (next_state.xmit_armed && !next_state.flags.xmit_empty_flag)
                begin
                    next_state.xmit_shift = next_state.xmit_hold;
                    next_state.xmit_last  = next_state.xmit_hold;
                    next_state.flags.xmit_empty_flag = 1'b1;
                    next_state.skip_pend  = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= '0;
            state.flags <= RESET_FLAGS;
            state.xmit_slot_mask_half_a <= RESET_MASK_HALF;
            state.xmit_slot_mask_half_b <= RESET_MASK_HALF;
            state.rcv_slot_mask_half_a  <= RESET_MASK_HALF;
            state.rcv_slot_mask_half_b  <= RESET_MASK_HALF;
            state.xmit_mask_shifter     <= RESET_MASK_FULL;
            state.rcv_mask_shifter      <= RESET_MASK_FULL;
            state.xmit_dropped          <= 1'b1;
            state.rcv_dropped           <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign rd_data             = state.rd_data;
    assign pins.serial_out_pin = state.xmit_shift[WORD_BITS-1];
    assign pins.serial_out_oe  = state.xmit_drive;
    assign pins.fs_out         = state.fs_out;
    assign pins.fs_oe          = state.ctrl.fs_internal;
    assign xmit_irq            = state.flags.xmit_empty_flag && state.ctrl.xmit_irq_enable &&
                                 state.xmit_armed;
    assign rcv_irq             = state.flags.rcv_full_flag && state.ctrl.rcv_irq_enable;

endmodule : tss_sequencer

//--- dv/tss_codec.sv
module tss_codec
(
    output logic             sck,
    output logic             fs,
    output logic             rxd,
    input  wire logic        sdo,
    input  wire logic        sdo_oe,
    input  wire logic [4:0]  div
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] q[$];
    logic [45:0] log_q[$];
    logic [15:0] cur;
    logic [15:0] got;
    logic        oe_seen;
    int          cnt;
    int          frm;
    // highway clock is continuous; frames are marked by a one-bit sync before slot 0
    initial
    begin
        {sck, fs, rxd, oe_seen} = 4'h0;
        cur = 16'h0000;
        got = 16'h0000;
        cnt = 0;
        frm = 0;
        forever
        begin
            #62.5 sck = 1'b0;
            cnt = (cnt + 1) % ((int'(div) + 1) * 16);
            if (cnt % 16 == 0)
            begin
                cur = (q.size() > 0) ? q.pop_front() : ~cur;
                frm += (cnt == 0);
                oe_seen = 1'b0;
            end
            rxd = cur[15 - cnt % 16];
            fs = (cnt == (int'(div) + 1) * 16 - 1);
            #62.5 sck = 1'b1;
            // a released line floats; show the inverse so stray sampling is caught
            got = {got[14:0], sdo_oe ? sdo : ~sdo};
            oe_seen = oe_seen | sdo_oe;
            if (cnt % 16 == 15)
                log_q.push_back({frm[7:0], 5'(cnt / 16), oe_seen, got, cur});
        end
    end
endmodule : tss_codec

//--- dv/tss_chk.sv
module tss_chk
(
    input wire logic                     ref_clk,
    input wire logic                     rst_n,
    input wire tss_pkg::tss_reg_req_type req,
    input wire logic                     sck_in,
    input wire tss_pkg::tss_pin_out_type pins,
    input wire logic                     xmit_irq,
    input wire logic                     rcv_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import tss_pkg::*;
    logic [7:0] on_cnt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // saturates, so runs of back-to-back slots never wrap
    always_ff @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
            on_cnt <= 8'h00;
        else if (!pins.serial_out_oe)
            on_cnt <= 8'h00;
        else if (on_cnt != 8'hFF)
            on_cnt <= on_cnt + 8'h01;
    property p_oe_rise; $rose(pins.serial_out_oe) |-> !sck_in; endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("drive began off a falling edge");
    property p_oe_fall; $fell(pins.serial_out_oe) |-> !sck_in; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("release off a falling edge");
    property p_oe_word; $fell(pins.serial_out_oe) |-> on_cnt >= 8'hBE; endproperty
    a_oe_word: assert property (p_oe_word) else $error("drive shorter than a word");
    property p_bit_step; pins.serial_out_oe && $changed(pins.serial_out_pin) |-> !sck_in; endproperty
    a_bit_step: assert property (p_bit_step) else $error("data moved while clock high");
    property p_tx_irq; $rose(xmit_irq) |-> !sck_in; endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("empty raised off a load edge");
    property p_rx_irq; $rose(rcv_irq) |-> sck_in; endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("full raised off a capture edge");
    property p_rx_clr; req.rd && req.addr == OFS_RCV_DATA |=> !rcv_irq; endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("full kept after data read");
    property p_tx_clr;
        req.wr && (req.addr == OFS_XMIT_DATA || req.addr == OFS_SKIP_SLOT) |=> !xmit_irq;
    endproperty
    a_tx_clr: assert property (p_tx_clr) else $error("empty kept after write");
    c_rx: cover property ($rose(rcv_irq));
    c_tx: cover property ($rose(pins.serial_out_oe));
    c_rd: cover property (req.rd && req.addr == OFS_RCV_DATA);
endmodule : tss_chk
bind tss_sequencer tss_chk tss_chk_inst (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
    .sck_in(sck_in), .pins(pins), .xmit_irq(xmit_irq), .rcv_irq(rcv_irq));

//--- dv/tss_sequencer_bench.sv
module tss_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tss_pkg::*;
    logic            ref_clk;
    logic            rst_n;
    tss_reg_req_type req;
    logic [15:0]     rd_data;
    tss_pin_out_type pins;
    logic            sck;
    logic            fs;
    logic            rxd;
    logic            tx_irq;
    logic            rx_irq;
    int              error_cnt;
    int              n_compared;
    int              arm;
    int              chg;
    logic [31:0]     m_old;
    logic [31:0]     m_new;
    logic [15:0]     d;
    logic [15:0]     e;
    logic [15:0]     w1;
    logic [45:0]     t;
    logic [3:0]      adr[4] = '{OFS_STATUS, OFS_RMASK_A, OFS_RMASK_B, 4'hF};
    logic [15:0]     rv[4] = '{16'h0001, 16'hFFFF, 16'hFFFF, 16'h0000};
    tss_sequencer tss_sequencer_inst (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
        .sck_in(sck), .fs_in(fs), .rxd_in(rxd), .pins(pins), .xmit_irq(tx_irq), .rcv_irq(rx_irq));
    tss_codec tss_codec_inst (.sck(sck), .fs(fs), .rxd(rxd), .sdo(pins.serial_out_pin),
        .sdo_oe(pins.serial_out_oe), .div(5'd16));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic stop_test;
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic check(input logic [16:0] s, input logic [16:0] x);
        n_compared++;
        if (s !== x)
        begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, x);
        end
    endtask : check
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] v, output logic [15:0] r);
        req <= '{wr: w, rd: !w, addr: a, wdata: v};
        @(posedge ref_clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        @(posedge ref_clk);
        r = rd_data;
    endtask : bus
    // b >= 0 polls a status bit, otherwise waits for a codec bit position
    task automatic poll(input int b, input int p);
        for (int i = 0; i < 4000; i++)
        begin
            if (b >= 0)
                bus(1'b0, OFS_STATUS, 16'h0000, d);
            else
                @(posedge ref_clk);
            if (b >= 0 ? d[b] === 1'b1 : tss_codec_inst.cnt == p)
                return;
        end
        check(17'h1, 17'h0);
        stop_test();
    endtask : poll
    task automatic next_rx(output logic [15:0] x);
        logic [31:0] m;
        while (tss_codec_inst.log_q.size() > 0)
        begin
            t = tss_codec_inst.log_q.pop_front();
            m = (t[45:38] >= chg) ? m_new : m_old;
            if (t[45:38] < arm)
                check(17'(t[32]), 17'h0);
            else if (t[45:38] == arm && t[37:33] == 5'd1)
                check(17'(t[32]), 17'h0);
            else if (t[45:38] == arm && t[37:33] < 5'd3)
                check(t[32:16], {1'b1, w1});
            if (t[45:38] >= arm && m[t[37:33]])
            begin
                x = t[15:0];
                return;
            end
        end
        check(17'h1, 17'h0);
        stop_test();
    endtask : next_rx
    initial
    begin
        req = '0;
        rst_n = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        arm = 255;
        chg = 255;
        void'($urandom(14035));
        w1 = 16'($urandom());
        repeat (200) tss_codec_inst.q.push_back(16'($urandom()));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (adr[i])
        begin
            bus(1'b0, adr[i], 16'h0000, d);
            check({1'b0, d}, {1'b0, rv[i]});
        end
        bus(1'b1, OFS_RMASK_A, 16'h0004, d);
        bus(1'b1, OFS_RMASK_B, 16'h0001, d);
        bus(1'b1, OFS_XMIT_DATA, w1, d);
        m_old = 32'h0001_0004;
        // shifters only reload at a frame's last slot, so let one unarmed frame run first
        poll(-1, 200);
        poll(-1, 20);
        bus(1'b1, OFS_CTRL, 16'h041F, d);
        arm = tss_codec_inst.frm + 1;
        poll(-1, 5);
        bus(1'b1, OFS_SKIP_SLOT, 16'h0000, d);
        for (int k = 0; k < 6; k++)
        begin
            if (k == 2)
            begin
                poll(-1, 40);
                bus(1'b1, OFS_RMASK_B, 16'h0000, d);
                bus(1'b1, OFS_RMASK_A, 16'h0002, d);
                m_new = 32'h0000_0002;
                chg = tss_codec_inst.frm + 1;
            end
            poll(1, 0);
            check(17'(rx_irq), 17'h1);
            bus(1'b0, OFS_RCV_DATA, 16'h0000, d);
            next_rx(e);
            check({1'b0, d}, {1'b0, e});
        end
        // leave the word unread so the next enabled slot overflows
        poll(3, 0);
        bus(1'b0, OFS_RCV_DATA, 16'h0000, d);
        next_rx(e);
        check({1'b0, d}, {1'b0, e});
        next_rx(e);
        bus(1'b0, OFS_STATUS, 16'h0000, d);
        check({15'h0, d[3], d[1]}, 17'h0);
        poll(-1, 200);
        bus(1'b0, OFS_STATUS, 16'h0000, d);
        check(17'(d[2]), 17'h1);
        check(17'(tx_irq), 17'h1);
        bus(1'b1, OFS_XMIT_DATA, w1, d);
        bus(1'b0, OFS_STATUS, 16'h0000, d);
        check(17'(d[2:0]), 17'h0);
        check(17'(tx_irq), 17'h0);
        stop_test();
    end
endmodule : tss_sequencer_bench
